//--- rmc_regs.sv
// Reset key, calibration trigger, mode select and input configuration
//
// Local design decision: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module rmc_regs #(
  parameter int ADDR_W = rmc_pkg::ADDR_W, // Register address width
  parameter int DATA_W = rmc_pkg::DATA_W // Register data width
) (
  input wire logic clk, // 10 MHz clock
  input wire logic rst_n, // Async power-up reset, active low
  input wire logic general_call_reset, // Bus general call reset pulse
  input wire logic fast_bus_mode, // Bus in high speed mode level
  input wire logic [ADDR_W-1:0] addr, // Register address
  input wire logic [DATA_W-1:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [DATA_W-1:0] rdata, // Read data, cycle after rd
  output logic soft_reset_pulse, // One-cycle device reset pulse
  output logic calibration_start, // One-cycle offset calibration pulse
  output logic auto_sequence_en, // Auto sequencing enabled
  output logic channel0_only, // Manual on channel 0 alone
  output logic [1:0] active_function, // Active function code
  output logic [1:0] input_pin_arrangement, // Input pin arrangement
  output logic dual_channel, // Two single-ended channels
  output logic remote_ground, // Single channel, remote ground sense
  output logic pseudo_diff // Single pseudo-differential channel
);
  typedef struct packed {
    logic fast_meta;
    logic fast_sync;
    logic [3:0] unlock_code;
    logic [2:0] mode_select_field;
    logic [1:0] input_cfg;
    logic soft_reset;
    logic cal_start;
    logic [7:0] rdata;
  } rmc_state_s;

  rmc_state_s q;
  rmc_state_s next_q;

  // Field layout is byte wide; other widths cannot be served
  if (ADDR_W != 8 || DATA_W != 8) begin : g_width_check
    $error("rmc_regs needs 8-bit address and data");
  end

  // Active function from the mode select code
  function automatic logic [1:0] rmc_fn(input logic [2:0] sel);
    case (sel)
      3'h6: rmc_fn = rmc_pkg::RMC_FN_AUTONOMOUS;
      3'h7: rmc_fn = rmc_pkg::RMC_FN_PRECISION;
      default: rmc_fn = rmc_pkg::RMC_FN_MANUAL;
    endcase
  endfunction : rmc_fn

  logic unlocked;
  logic [7:0] status_word;
  assign unlocked = (q.unlock_code == rmc_pkg::UNLOCK_CODE_VALUE);
  assign status_word = {5'h00, q.fast_sync, rmc_fn(q.mode_select_field)};

  always_comb begin
    next_q = q;
    next_q.fast_meta = fast_bus_mode;
    next_q.fast_sync = q.fast_meta;
    next_q.soft_reset = 1'b0;
    next_q.cal_start = 1'b0;
    next_q.rdata = 8'h00;
    if (wr) begin
      case (addr)
        rmc_pkg::OFS_UNLOCK: begin
          next_q.unlock_code = wdata[3:0];
        end
        rmc_pkg::OFS_SOFT_RESET: begin
          // Locked writes drop silently
          next_q.soft_reset = unlocked &
                              wdata[rmc_pkg::TRIGGER_BIT];
        end
        rmc_pkg::OFS_CAL: begin
          next_q.cal_start = wdata[rmc_pkg::TRIGGER_BIT];
        end
        rmc_pkg::OFS_MODE_SEL: begin
          next_q.mode_select_field = wdata[2:0];
        end
        rmc_pkg::OFS_INPUT_CFG: begin
          next_q.input_cfg = wdata[1:0];
        end
        default: begin
        end
      endcase
    end
    if (rd) begin
      case (addr)
        rmc_pkg::OFS_STATUS: next_q.rdata = status_word;
        rmc_pkg::OFS_UNLOCK: next_q.rdata = {4'h0, q.unlock_code};
        rmc_pkg::OFS_MODE_SEL: next_q.rdata = {5'h00, q.mode_select_field};
        rmc_pkg::OFS_INPUT_CFG: next_q.rdata = {6'h00, q.input_cfg};
        default: next_q.rdata = 8'h00;
      endcase
    end
    // Soft reset clears mode, input config, pulses and read data; the key and fast bus sync flops stay
    if (q.soft_reset || general_call_reset) begin
      next_q.mode_select_field = rmc_pkg::RST_MODE_SEL;
      next_q.input_cfg = rmc_pkg::RST_INPUT_CFG;
      next_q.cal_start = 1'b0;
      next_q.soft_reset = 1'b0;
      next_q.rdata = 8'h00;
    end
    if (general_call_reset) begin
      next_q.unlock_code = rmc_pkg::RST_UNLOCK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign rdata = q.rdata;
  assign soft_reset_pulse = q.soft_reset;
  assign calibration_start = q.cal_start;
  assign active_function = rmc_fn(q.mode_select_field);
  assign auto_sequence_en = q.mode_select_field[2];
  assign channel0_only = ~q.mode_select_field[2];
  assign input_pin_arrangement = q.input_cfg;
  assign dual_channel = (q.input_cfg == rmc_pkg::RMC_IN_TWO_SE) ||
                        (q.input_cfg == rmc_pkg::RMC_IN_TWO_SE_ALT);
  assign remote_ground = (q.input_cfg == rmc_pkg::RMC_IN_ONE_SE_RGS);
  assign pseudo_diff = (q.input_cfg == rmc_pkg::RMC_IN_ONE_PDIFF);

  // Checks on the bus-visible behaviour of the bank
  AST_LOCKED_WRITE_IGNORED: assert property (
    @(posedge clk) disable iff (!rst_n)
    (wr && addr == rmc_pkg::OFS_SOFT_RESET && !unlocked)
    |=> !soft_reset_pulse)
    else $error("soft reset fired while locked");

  AST_UNLOCKED_RESET_FIRES: assert property (
    @(posedge clk) disable iff (!rst_n)
    (wr && addr == rmc_pkg::OFS_SOFT_RESET && unlocked &&
     wdata[rmc_pkg::TRIGGER_BIT] && !soft_reset_pulse &&
     !general_call_reset)
    |=> soft_reset_pulse)
    else $error("unlocked soft reset not issued");

  AST_SOFT_RESET_CLEARS_MODE: assert property (
    @(posedge clk) disable iff (!rst_n)
    soft_reset_pulse
    |=> (q.mode_select_field == rmc_pkg::RST_MODE_SEL &&
         q.input_cfg == rmc_pkg::RST_INPUT_CFG && rdata == 8'h00))
    else $error("soft reset left mode set");

  AST_KEY_SURVIVES_SOFT_RESET: assert property (
    @(posedge clk) disable iff (!rst_n)
    (soft_reset_pulse && !general_call_reset &&
     !(wr && addr == rmc_pkg::OFS_UNLOCK))
    |=> $stable(q.unlock_code))
    else $error("key lost on soft reset");

  AST_SOFT_PULSE_SINGLE: assert property (
    @(posedge clk) disable iff (!rst_n)
    soft_reset_pulse |=> !soft_reset_pulse)
    else $error("soft reset pulse longer than one cycle");

  AST_RESET_ONLY_WHEN_UNLOCKED: assert property (
    @(posedge clk) disable iff (!rst_n)
    soft_reset_pulse
    |-> $past(wr && addr == rmc_pkg::OFS_SOFT_RESET && unlocked &&
              wdata[rmc_pkg::TRIGGER_BIT]))
    else $error("soft reset without an unlocked write");

  AST_CAL_PULSE: assert property (
    @(posedge clk) disable iff (!rst_n)
    (wr && addr == rmc_pkg::OFS_CAL && wdata[rmc_pkg::TRIGGER_BIT] &&
     !general_call_reset && !soft_reset_pulse)
    |=> calibration_start ##1
    (!calibration_start || $past(wr && addr == rmc_pkg::OFS_CAL &&
                                 wdata[rmc_pkg::TRIGGER_BIT])))
    else $error("calibration pulse wrong");

  AST_CAL_ONLY_ON_WRITE: assert property (
    @(posedge clk) disable iff (!rst_n)
    calibration_start
    |-> $past(wr && addr == rmc_pkg::OFS_CAL &&
              wdata[rmc_pkg::TRIGGER_BIT]))
    else $error("calibration pulse without a write");

  AST_KEY_WRITE_TAKES: assert property (
    @(posedge clk) disable iff (!rst_n)
    (wr && addr == rmc_pkg::OFS_UNLOCK && !general_call_reset)
    |=> q.unlock_code == $past(wdata[3:0]))
    else $error("unlock code not stored");

  AST_KEY_UPPER_ZERO: assert property (
    @(posedge clk) disable iff (!rst_n)
    (rd && addr == rmc_pkg::OFS_UNLOCK) |=> rdata[7:4] == 4'h0)
    else $error("key upper bits nonzero");

  AST_KEY_READ_BACK: assert property (
    @(posedge clk) disable iff (!rst_n)
    (rd && addr == rmc_pkg::OFS_UNLOCK && !soft_reset_pulse &&
     !general_call_reset)
    |=> rdata[3:0] == $past(q.unlock_code))
    else $error("unlock code read back wrong");

  AST_TRIGGER_READ_ZERO: assert property (
    @(posedge clk) disable iff (!rst_n)
    (rd && (addr == rmc_pkg::OFS_SOFT_RESET || addr == rmc_pkg::OFS_CAL))
    |=> rdata == 8'h00)
    else $error("trigger register read nonzero");

  AST_IDLE_READ_ZERO: assert property (
    @(posedge clk) disable iff (!rst_n)
    !rd |=> rdata == 8'h00)
    else $error("read data outside a read cycle");

  AST_STATUS_FUNCTION: assert property (
    @(posedge clk) disable iff (!rst_n)
    (rd && addr == rmc_pkg::OFS_STATUS && !soft_reset_pulse &&
     !general_call_reset)
    |=> (rdata[1:0] == $past(active_function) && rdata[7:3] == 5'h00))
    else $error("status function wrong");

  AST_NO_FUNCTION_01: assert property (
    @(posedge clk) disable iff (!rst_n)
    active_function != 2'b01)
    else $error("unused function code reported");

  AST_FAST_BUS_FLAG: assert property (
    @(posedge clk) disable iff (!rst_n)
    (rd && addr == rmc_pkg::OFS_STATUS && !soft_reset_pulse &&
     !general_call_reset)
    |=> rdata[2] == $past(fast_bus_mode, 3))
    else $error("fast bus flag wrong");

  AST_MODE_DECODE: assert property (
    @(posedge clk) disable iff (!rst_n)
    (auto_sequence_en == (q.mode_select_field >= 3'h4) &&
     channel0_only == (q.mode_select_field <= 3'h3) &&
     active_function == ((q.mode_select_field == 3'h6) ? 2'b10 :
                         (q.mode_select_field == 3'h7) ? 2'b11 : 2'b00)))
    else $error("mode decode wrong");

  AST_MODE_WRITE_TAKES: assert property (
    @(posedge clk) disable iff (!rst_n)
    (wr && addr == rmc_pkg::OFS_MODE_SEL && !general_call_reset &&
     !soft_reset_pulse)
    |=> q.mode_select_field == $past(wdata[2:0]))
    else $error("mode select not stored");

  AST_MODE_READ_UPPER_ZERO: assert property (
    @(posedge clk) disable iff (!rst_n)
    (rd && addr == rmc_pkg::OFS_MODE_SEL) |=> rdata[7:3] == 5'h00)
    else $error("mode select upper bits nonzero");

  AST_CFG_WRITE_TAKES: assert property (
    @(posedge clk) disable iff (!rst_n)
    (wr && addr == rmc_pkg::OFS_INPUT_CFG && !general_call_reset &&
     !soft_reset_pulse)
    |=> q.input_cfg == $past(wdata[1:0]))
    else $error("input config not stored");

  AST_CFG_READ_UPPER_ZERO: assert property (
    @(posedge clk) disable iff (!rst_n)
    (rd && addr == rmc_pkg::OFS_INPUT_CFG) |=> rdata[7:2] == 6'h00)
    else $error("input config upper bits nonzero");

  AST_CFG_READ_BACK: assert property (
    @(posedge clk) disable iff (!rst_n)
    (wr && addr == rmc_pkg::OFS_INPUT_CFG && !general_call_reset &&
     !soft_reset_pulse) ##1
    (!wr && !general_call_reset && !soft_reset_pulse) ##1
    (rd && addr == rmc_pkg::OFS_INPUT_CFG && !general_call_reset &&
     !soft_reset_pulse)
    |=> rdata == {6'h00, $past(wdata[1:0], 3)})
    else $error("input config read back wrong");

  AST_INPUT_DECODE: assert property (
    @(posedge clk) disable iff (!rst_n)
    (dual_channel == (input_pin_arrangement[1] == input_pin_arrangement[0])
     && remote_ground == (input_pin_arrangement == 2'b01) &&
     pseudo_diff == (input_pin_arrangement == 2'b10)))
    else $error("input arrangement decode wrong");

  AST_GC_CLEARS_ALL: assert property (
    @(posedge clk) disable iff (!rst_n)
    general_call_reset
    |=> (q.unlock_code == rmc_pkg::RST_UNLOCK &&
         q.mode_select_field == rmc_pkg::RST_MODE_SEL &&
         q.input_cfg == rmc_pkg::RST_INPUT_CFG && rdata == 8'h00 &&
         !soft_reset_pulse && !calibration_start))
    else $error("general call reset left state behind");
endmodule : rmc_regs
`default_nettype wire

//--- rmc_pkg.sv
// Package with offsets, fields and codes of the mode control registers
package rmc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_SOFT_RESET = 8'h14;
  localparam logic [7:0] OFS_CAL = 8'h15;
  localparam logic [7:0] OFS_UNLOCK = 8'h17;
  localparam logic [7:0] OFS_MODE_SEL = 8'h1c;
  localparam logic [7:0] OFS_INPUT_CFG = 8'h24;
  localparam logic [3:0] UNLOCK_CODE_VALUE = 4'ha;
  localparam logic [3:0] RST_UNLOCK = 4'h0;
  localparam logic [2:0] RST_MODE_SEL = 3'h0;
  localparam logic [1:0] RST_INPUT_CFG = 2'h0;
  localparam int TRIGGER_BIT = 0;
  localparam int FAST_BUS_BIT = 2;
  // Active function codes reported in status
  typedef enum logic [1:0] {
    RMC_FN_MANUAL = 2'b00,
    RMC_FN_AUTONOMOUS = 2'b10,
    RMC_FN_PRECISION = 2'b11
  } rmc_fn_e;
  // Input pin arrangements
  typedef enum logic [1:0] {
    RMC_IN_TWO_SE = 2'b00,
    RMC_IN_ONE_SE_RGS = 2'b01,
    RMC_IN_ONE_PDIFF = 2'b10,
    RMC_IN_TWO_SE_ALT = 2'b11
  } rmc_in_e;
endpackage : rmc_pkg

//--- rmc_host.sv
// Host model that drives the register port of the mode control bank
`timescale 1ns/1ns
`default_nettype none
module rmc_host (
  input wire logic clk, // Clock
  input wire logic [7:0] rdata, // Read data from the bank
  output logic [7:0] addr, // Address
  output logic [7:0] wdata, // Write data
  output logic wr, // Write strobe
  output logic rd // Read strobe
);
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= (a == 8'h17) ? (d & 8'h0f) : d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    #1 d = rdata;
  endtask : rd_reg
endmodule : rmc_host
`default_nettype wire

//--- tb.sv
// Self-checking bench for the mode control register bank
`timescale 1ns/1ns
`default_nettype none
`define CHK(n,e,g) begin total_checks++; if ((g) !== (e)) begin \
  err_total++; $display("ERROR %s exp %h got %h", n, e, g); end end
module tb;
  logic clk, rst_n, gcr, fast, sr, cal, aseq, ch0, dual, rgs, pd, wr, rd;
  logic [7:0] addr, wdata, rdata, d;
  logic [1:0] fn, ipa;
  logic [8:0] exp_lv;
  logic [7:0] rnd;
  int err_total, total_checks, seed, mode, cfg, i, key;
  int codes[6] = '{0, 1, 4, 5, 6, 7};
  rmc_regs uut (.clk(clk), .rst_n(rst_n), .general_call_reset(gcr),
    .fast_bus_mode(fast), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .soft_reset_pulse(sr), .calibration_start(cal),
    .auto_sequence_en(aseq), .channel0_only(ch0), .active_function(fn),
    .input_pin_arrangement(ipa), .dual_channel(dual),
    .remote_ground(rgs), .pseudo_diff(pd));
  rmc_host host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd));
  function automatic logic [1:0] f(int m);
    return (m[2:1] == 2'b11) ? {1'b1, m[0]} : 2'b00;
  endfunction : f
  task automatic finish_test;
    if (err_total == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  task automatic chk_cfg;
    host.rd_reg(8'h24, d);
    `CHK("cfg", cfg[7:0], d)
    host.rd_reg(8'h1c, d);
    `CHK("mode", mode[7:0], d)
    host.rd_reg(8'h00, d);
    `CHK("status", {5'b0, fast, f(mode)}, d)
    exp_lv = {mode[2], ~mode[2], f(mode), cfg[1:0], cfg == 0 || cfg == 3,
      cfg == 1, cfg == 2};
    `CHK("levels", exp_lv, {aseq, ch0, fn, ipa, dual, rgs, pd})
  endtask : chk_cfg
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #400000;
    err_total++;
    finish_test();
  end
  initial begin
    rst_n = 1'b0;
    gcr = 1'b0;
    fast = 1'b0;
    seed = 32'h2c18_1f55;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    chk_cfg();
    foreach (codes[i]) begin
      host.rd_reg(8'h14 + i[7:0], d);
      `CHK("zero", 8'h00, d)
    end
    for (i = 0; i < 12; i++) begin
      mode = codes[(i < 6) ? i : $unsigned($random(seed)) % 6];
      cfg = (i < 4) ? i : $unsigned($random(seed)) % 4;
      rnd = 8'($random(seed));
      host.wr_reg(8'h1c, {rnd[7:3], mode[2:0]});
      host.wr_reg(8'h24, {rnd[5:0], cfg[1:0]});
      chk_cfg();
    end
    host.wr_reg(8'h15, 8'hff);
    #1 `CHK("cal", 1'b1, cal)
    host.rd_reg(8'h15, d);
    `CHK("calrd", 8'h00, d)
    host.wr_reg(8'h15, {rnd[7:1], 1'b0});
    #1 `CHK("calzero", 1'b0, cal)
    key = (($random(seed) & 15) == 10) ? 5 : $random(seed) & 15;
    if (key == 10) key = 3;
    host.wr_reg(8'h17, key[7:0]);
    host.wr_reg(8'h14, 8'h01);
    #1 `CHK("locked", 1'b0, sr)
    chk_cfg();
    host.wr_reg(8'h17, 8'h0a);
    host.rd_reg(8'h17, d);
    `CHK("key", 8'h0a, d)
    host.wr_reg(8'h14, {rnd[7:1], 1'b0});
    #1 `CHK("srzero", 1'b0, sr)
    host.wr_reg(8'h14, 8'h01);
    #1 `CHK("sreset", 1'b1, sr)
    mode = 0;
    cfg = 0;
    chk_cfg();
    host.rd_reg(8'h17, d);
    `CHK("keykept", 8'h0a, d)
    host.wr_reg(8'h17, 8'h00);
    @(posedge clk) fast <= 1'b1;
    repeat (4) @(posedge clk);
    chk_cfg();
    host.wr_reg(8'h17, 8'h0a);
    host.wr_reg(8'h1c, 8'h06);
    @(posedge clk) gcr <= 1'b1;
    @(posedge clk) gcr <= 1'b0;
    chk_cfg();
    host.rd_reg(8'h17, d);
    `CHK("gckey", 8'h00, d)
    host.wr_reg(8'h17, 8'h0a);
    host.wr_reg(8'h1c, 8'h07);
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    chk_cfg();
    host.rd_reg(8'h17, d);
    `CHK("rstkey", 8'h00, d)
    finish_test();
  end
endmodule : tb
`default_nettype wire
